// >>> pkg/srm_pkg.sv
// Constants, instruction layouts and carriers for the skip/repeat/misc executor.
// Assumes one core clock; memory answers each request with a one-cycle ack.
package srm_pkg;
	localparam int          SIGN_BIT     = 15;
	localparam logic [3:0]  MAJ_ZERO     = 4'h0;
	localparam logic [3:0]  SUB_SKIP     = 4'h0;
	localparam logic [3:0]  SUB_FIELD    = 4'h5;
	localparam logic [3:0]  SUB_REPEAT   = 4'h6;
	localparam logic [3:0]  SUB_XFER     = 4'h7;
	localparam logic [3:0]  SUB_MISC     = 4'hB;
	localparam logic [2:0]  FOP_SET      = 3'h7;
	localparam logic [1:0]  XOP_COPY     = 2'h0;
	localparam logic [3:0]  MOP_LOAD_UM  = 4'h1;
	localparam logic [3:0]  MOP_RESTORE  = 4'h2;
	localparam logic [1:0]  TST_ZERO     = 2'h0;
	localparam logic [1:0]  TST_NZ       = 2'h1;
	localparam logic [1:0]  TST_POS      = 2'h2;
	localparam logic [1:0]  TST_NEG      = 2'h3;
	localparam logic [3:0]  IDX_R1       = 4'h1;
	localparam logic [3:0]  IDX_R2       = 4'h2;
	localparam logic [3:0]  IDX_R4       = 4'h4;
	localparam logic [3:0]  IDX_Q        = 4'h5;
	localparam logic [3:0]  IDX_M        = 4'h8;
	localparam logic [3:0]  RESTORE_LAST = 4'h9;
	localparam logic [15:0] ONE_W        = 16'h0001;
	localparam logic [15:0] TWO_W        = 16'h0002;
	localparam logic [15:0] MINUS_ONE    = 16'hFFFE;
	localparam logic [15:0] RESTORE_STEP = 16'h000A;

	// Index 1..8 holds R1, R2, R3, R4, Q, A, I, M; index 0 unused
	typedef logic [8:0][15:0] srm_rf_t;

	typedef struct packed {
		logic [3:0] maj;
		logic [3:0] sub;
		logic [3:0] cnd;
		logic [3:0] cnt;
	} srm_skip_s;
	typedef struct packed {
		logic [3:0] maj;
		logic [3:0] sub;
		logic [2:0] ra;
		logic       b4;
		logic [3:0] low;
	} srm_rep_s;
	typedef struct packed {
		logic [3:0] maj;
		logic [3:0] sub;
		logic [2:0] ra;
		logic [1:0] op;
		logic [2:0] rb;
	} srm_xfer_s;
	typedef struct packed {
		logic [3:0] maj;
		logic [3:0] sub;
		logic       r;
		logic       i;
		logic [2:0] ra;
		logic [2:0] op;
	} srm_fref_s;
	typedef struct packed {
		logic [3:0] start;
		logic [3:0] len_m1;
		logic [7:0] rest;
	} srm_fword_s;
	typedef struct packed {
		logic [2:0] zero;
		logic [3:0] page;
		logic [7:0] word;
		logic       half;
	} srm_uaddr_s;

	typedef enum logic [3:0] {
		ST_IDLE, ST_FLD_RD, ST_FLD_WR, ST_UM_HI, ST_UM_LO, ST_RS_PTR, ST_RS_RD, ST_RS_WB
	} srm_state_e;

	typedef struct packed {
		logic        req;
		logic        we;
		logic        lock;
		logic [15:0] addr;
		logic [15:0] wdata;
	} srm_mem_s;
	typedef struct packed {
		logic        we;
		logic [12:0] addr;
		logic [31:0] data;
	} srm_um_s;
	typedef struct packed {
		logic        done;
		logic        alt;
		logic        viol;
		logic        rsvd;
		logic        intr;
		logic [15:0] next_p;
	} srm_res_s;
	typedef struct packed {
		srm_state_e  state;
		logic        busy;
		srm_rf_t     rf;
		logic        ovf;
		srm_mem_s    mem;
		srm_um_s     um;
		srm_res_s    res;
		logic [15:0] ins;
		logic [15:0] p;
		logic [15:0] ext;
		logic [15:0] pnext;
		logic [15:0] ptr;
		logic [15:0] hi;
		logic [3:0]  cnt;
	} srm_st_s;
endpackage : srm_pkg

// >>> rtl/srm_oc_add.sv
// One's-complement 16-bit adder with end-around carry and add overflow.
// Purely combinational; used for decrement and for the restore pointer step.
`timescale 1ns/100ps
module srm_oc_add (
	input  wire logic [15:0] i_a,
	input  wire logic [15:0] i_b,
	output logic      [15:0] o_sum,
	output logic             o_ovf
);
	logic [16:0] raw;

	always_comb begin
		raw   = {1'b0, i_a} + {1'b0, i_b};
		o_sum = raw[15:0] + {15'h0000, raw[16]};
		o_ovf = (i_a[15] == i_b[15]) && (o_sum[15] != i_a[15]);
	end
endmodule : srm_oc_add

// >>> rtl/srm_fld_mask.sv
// Builds the bit mask of a word field from its start bit and length minus one.
// Flags fields that would run past bit 0; such a mask is returned empty.
`timescale 1ns/100ps
module srm_fld_mask (
	input  wire logic [3:0]  i_start,
	input  wire logic [3:0]  i_len_m1,
	output logic      [15:0] o_mask,
	output logic             o_bad
);
	logic [4:0]  low;
	logic [16:0] span;

	always_comb begin
		o_bad  = i_len_m1 > i_start; // [RL21]
		low    = {1'b0, i_start} - {1'b0, i_len_m1};
		span   = (17'h00002 << i_len_m1) - 17'h00001;
		o_mask = o_bad ? 16'h0000 : 16'(span[15:0] << low[3:0]); // [RL21]
	end
endmodule : srm_fld_mask

// >>> rtl/srm_exec.sv
// Executor for set-field, register skip, decrement-repeat, register transfer
// and the privileged micromemory load / register restore group.
// Assumes: memory takes a held req and answers with a one-cycle ack;
// instructions arrive only while O_BUSY is low.
`timescale 1ns/100ps
// Notes on behaviour
// RL1: Set field writes ones into the field, keeps other bits, memory locked.
// RL2: Skip decodes with top bytes zero unless condition and count both zero.
// RL3: Skip taken goes to P plus count plus one, else P plus one.
// RL4: Condition low bits pick test, high bits pick register four or one to three.
// RL5: Zero is all clear, positive is bit 15 clear, negative bit 15 set.
// RL6: Repeat decodes with subgroup six, bit 4 clear, not register and count zero.
// RL7: Repeat decrements register like add; non-negative result goes back by count.
// RL8: Register codes one to seven select R1 to R4, Q, A, I.
// RL9: Zero register code or bit 4 set in repeat format is reserved.
// RL10: Transfer decodes with subgroup seven unless all three fields are zero.
// RL11: Operation zero copies source to destination; others and zero registers reserved.
// RL12: Misc group is subgroup B, bit 4 clear; both fields zero is no-op.
// RL13: Misc instructions from unprotected programs raise a protect violation instead.
// RL14: Nonzero register field takes operand ops; zero field takes operand-less ops.
// RL15: Micromemory load copies Q 32-bit words from R2 area to R1 address.
// RL16: Micromemory address is page, word within page and upper or lower half.
// RL17: Load may stop after each word with Q, R1, R2 kept restartable.
// RL18: Restore reads pointer, loads eight registers and overflow from nine words.
// RL19: Restore then writes the pointer back reduced by ten.
// RL20: Restore leaves save words alone and continues at P plus two.
// RL21: Field starts at start bit and spans length toward bit 0.
// RL22: Locked field update keeps other requesters off between read and write.
module srm_exec
	import srm_pkg::*;
(
	input  wire logic          I_CORE_CLK,
	input  wire logic          I_SYS_RST,
	input  wire logic          I_ISSUE,
	input  wire logic [15:0]   I_INSTR,
	input  wire logic [15:0]   I_EXT_WORD,
	input  wire logic [15:0]   I_P,
	input  wire logic [15:0]   I_P_AFTER,
	input  wire logic [15:0]   I_EA,
	input  wire logic          I_PROG_PROTECTED,
	input  wire logic          I_INTR_PEND,
	input  wire logic          I_MEM_ACK,
	input  wire logic [15:0]   I_MEM_RDATA,
	input  wire logic          I_RF_WE,
	input  wire logic [3:0]    I_RF_IDX,
	input  wire logic [15:0]   I_RF_WDATA,
	output srm_mem_s           O_MEM,
	output srm_um_s            O_UM,
	output srm_res_s           O_RES,
	output srm_rf_t            O_REGS,
	output logic               O_OVF,
	output logic               O_BUSY
);
	srm_st_s     s_q;
	srm_st_s     s_d;
	srm_skip_s   sk;
	srm_rep_s    rp;
	srm_xfer_s   xf;
	srm_fref_s   fr;
	srm_xfer_s   xq;
	srm_fword_s  fw;
	srm_uaddr_s  ua;
	logic        take;
	logic        top0;
	logic        dec_skip;
	logic        rep_ok;
	logic        xfer_ok;
	logic        misc_nz;
	logic        is_lmm;
	logic [3:0]  sel_idx;
	logic [15:0] sel_val;
	logic        hit;
	logic [15:0] skip_tgt;
	logic [15:0] skip_next;
	logic [15:0] rep_back;
	logic [15:0] dec_sum;
	logic        dec_ovf;
	logic [15:0] xf_src;
	logic [15:0] ptr_m10;
	logic [15:0] fmask;
	logic        fbad;

	assign sk       = srm_skip_s'(I_INSTR);
	assign rp       = srm_rep_s'(I_INSTR);
	assign xf       = srm_xfer_s'(I_INSTR);
	assign fr       = srm_fref_s'(I_INSTR);
	assign xq       = srm_xfer_s'(s_q.ins);
	assign fw       = srm_fword_s'((s_q.state == ST_IDLE) ? I_EXT_WORD : s_q.ext);
	assign ua       = srm_uaddr_s'(s_q.rf[IDX_R1]); // [RL16]
	assign take     = I_ISSUE && (s_q.state == ST_IDLE);
	assign top0     = sk.maj == MAJ_ZERO;
	assign dec_skip = top0 && (sk.sub == SUB_SKIP) && ({sk.cnd, sk.cnt} != 8'h00); // [RL2]
	assign rep_ok   = top0 && (rp.sub == SUB_REPEAT) && !rp.b4 && (rp.ra != 3'h0); // [RL6]
	assign xfer_ok  = top0 && (xf.sub == SUB_XFER) && (xf.op == XOP_COPY)
		&& (xf.ra != 3'h0) && (xf.rb != 3'h0);
	assign misc_nz  = top0 && (rp.sub == SUB_MISC) && !rp.b4 && ({rp.ra, rp.low} != 7'h00);
	assign is_lmm   = misc_nz && (rp.ra == 3'h0) && (rp.low == MOP_LOAD_UM);
	// Test register: code 0 means R4 so that R1-R3 keep their own codes
	assign sel_idx  = (sk.cnd[3:2] == 2'h0) ? IDX_R4 : {2'h0, sk.cnd[3:2]}; // [RL4]
	assign sel_val  = s_q.rf[sel_idx];
	assign skip_tgt = I_P + {12'h000, sk.cnt} + ONE_W; // [RL3]
	assign skip_next = hit ? skip_tgt : I_P + ONE_W;
	assign rep_back = I_P - {12'h000, rp.low}; // [RL7]
	assign xf_src   = s_q.rf[{1'b0, xf.ra}]; // [RL8]

	always_comb begin
		case (sk.cnd[1:0]) // [RL4]
			TST_ZERO: hit = sel_val == 16'h0000; // [RL5]
			TST_NZ:   hit = sel_val != 16'h0000; // [RL5]
			TST_POS:  hit = !sel_val[SIGN_BIT]; // [RL5]
			TST_NEG:  hit = sel_val[SIGN_BIT]; // [RL5]
			default:  hit = 1'b0;
		endcase
	end

	srm_oc_add u_dec (
		.i_a   (s_q.rf[{1'b0, rp.ra}]),
		.i_b   (MINUS_ONE),
		.o_sum (dec_sum),
		.o_ovf (dec_ovf)
	);

	srm_oc_add u_ptr (
		.i_a   (s_q.ptr),
		.i_b   (~RESTORE_STEP),
		.o_sum (ptr_m10),
		.o_ovf ()
	);

	srm_fld_mask u_mask (
		.i_start  (fw.start),
		.i_len_m1 (fw.len_m1),
		.o_mask   (fmask),
		.o_bad    (fbad)
	);

	always_comb begin
		s_d       = s_q;
		s_d.res   = '0;
		s_d.um.we = 1'b0;
		case (s_q.state)
			ST_IDLE: begin
				if (I_RF_WE && (I_RF_IDX <= IDX_M) && !I_ISSUE) begin
					s_d.rf[I_RF_IDX] = I_RF_WDATA;
				end
				if (I_ISSUE) begin
					s_d.ins        = I_INSTR;
					s_d.p          = I_P;
					s_d.ext        = I_EXT_WORD;
					s_d.pnext      = I_P_AFTER;
					s_d.res.done   = 1'b1;
					s_d.res.next_p = I_P + ONE_W;
					if (!top0) begin
						s_d.res.alt = 1'b1;
					end else begin
						case (sk.sub)
							SUB_SKIP: begin
								if (!dec_skip) begin
									s_d.res.alt = 1'b1; // [RL2]
								end else begin
									s_d.res.next_p = skip_next; // [RL3]
								end
							end
							SUB_REPEAT: begin
								if (rp.b4) begin
									s_d.res.rsvd = 1'b1; // [RL9]
								end else if ({rp.ra, rp.low} == 7'h00) begin
									s_d.res.alt = 1'b1; // [RL6]
								end else if (rp.ra == 3'h0) begin
									s_d.res.rsvd = 1'b1; // [RL9]
								end else begin
									s_d.rf[{1'b0, rp.ra}] = dec_sum; // [RL7] [RL8]
									s_d.ovf = s_q.ovf | dec_ovf; // [RL7]
									if (!dec_sum[SIGN_BIT]) begin
										s_d.res.next_p = rep_back; // [RL7]
									end
								end
							end
							SUB_XFER: begin
								if ({xf.ra, xf.op, xf.rb} == 8'h00) begin
									s_d.res.alt = 1'b1; // [RL10]
								end else if (!xfer_ok) begin
									s_d.res.rsvd = 1'b1; // [RL11]
								end else begin
									s_d.rf[{1'b0, xf.rb}] = xf_src; // [RL11] [RL8]
								end
							end
							SUB_MISC: begin
								if (rp.b4) begin
									s_d.res.alt = 1'b1;
								end else if (!misc_nz) begin
									s_d.res.done = 1'b1; // [RL12]
								end else if (!I_PROG_PROTECTED) begin
									s_d.res.viol = 1'b1; // [RL13]
								end else if (rp.ra != 3'h0) begin
									s_d.res.alt = 1'b1; // [RL14]
								end else if (rp.low == MOP_LOAD_UM) begin
									// Zero count finishes at once with nothing moved
									if (s_q.rf[IDX_Q] != 16'h0000) begin
										s_d.res.done = 1'b0; // [RL15]
										s_d.mem.req  = 1'b1;
										s_d.mem.we   = 1'b0;
										s_d.mem.addr = s_q.rf[IDX_R2];
										s_d.state    = ST_UM_HI;
									end
								end else if (rp.low == MOP_RESTORE) begin
									s_d.res.done = 1'b0;
									s_d.mem.req  = 1'b1;
									s_d.mem.we   = 1'b0;
									s_d.mem.addr = I_EXT_WORD; // [RL18]
									s_d.state    = ST_RS_PTR;
								end else begin
									s_d.res.alt = 1'b1; // [RL14]
								end
							end
							SUB_FIELD: begin
								if (fr.op != FOP_SET) begin
									s_d.res.alt = 1'b1;
								end else if (fbad) begin
									s_d.res.rsvd = 1'b1; // [RL21]
								end else begin
									s_d.res.done = 1'b0;
									s_d.mem.req  = 1'b1;
									s_d.mem.we   = 1'b0;
									s_d.mem.lock = 1'b1; // [RL1] [RL22]
									s_d.mem.addr = I_EA;
									s_d.state    = ST_FLD_RD;
								end
							end
							default: s_d.res.alt = 1'b1;
						endcase
					end
					// Handed-off, reserved and refused cases do not report completion
					if (s_d.res.alt || s_d.res.viol || s_d.res.rsvd) begin
						s_d.res.done = 1'b0;
					end
				end
			end
			ST_FLD_RD: begin
				if (I_MEM_ACK) begin
					s_d.mem.we    = 1'b1;
					s_d.mem.wdata = I_MEM_RDATA | fmask; // [RL1]
					s_d.state     = ST_FLD_WR;
				end
			end
			ST_FLD_WR: begin
				// Lock held from read through write ack
				if (I_MEM_ACK) begin
					s_d.mem        = '0; // [RL22]
					s_d.res.done   = 1'b1;
					s_d.res.next_p = s_q.pnext;
					s_d.state      = ST_IDLE;
				end
			end
			ST_UM_HI: begin
				if (I_MEM_ACK) begin
					s_d.hi       = I_MEM_RDATA;
					s_d.mem.addr = s_q.rf[IDX_R2] + ONE_W;
					s_d.state    = ST_UM_LO;
				end
			end
			ST_UM_LO: begin
				if (I_MEM_ACK) begin
					s_d.um.we         = 1'b1;
					s_d.um.addr       = {ua.page, ua.word, ua.half}; // [RL16]
					s_d.um.data       = {s_q.hi, I_MEM_RDATA}; // [RL15]
					s_d.rf[IDX_R1]    = s_q.rf[IDX_R1] + ONE_W; // [RL17]
					s_d.rf[IDX_R2]    = s_q.rf[IDX_R2] + TWO_W; // [RL17]
					s_d.rf[IDX_Q]     = s_q.rf[IDX_Q] - ONE_W; // [RL17]
					s_d.mem.addr      = s_q.rf[IDX_R2] + TWO_W;
					if (s_q.rf[IDX_Q] == ONE_W) begin
						s_d.mem.req    = 1'b0;
						s_d.res.done   = 1'b1;
						s_d.res.next_p = s_q.p + ONE_W;
						s_d.state      = ST_IDLE;
					end else if (I_INTR_PEND) begin
						// Resume point is the instruction itself
						s_d.mem.req    = 1'b0;
						s_d.res.intr   = 1'b1; // [RL17]
						s_d.res.next_p = s_q.p;
						s_d.state      = ST_IDLE;
					end else begin
						s_d.state = ST_UM_HI;
					end
				end
			end
			ST_RS_PTR: begin
				if (I_MEM_ACK) begin
					s_d.ptr      = I_MEM_RDATA; // [RL18]
					s_d.cnt      = IDX_R1;
					s_d.mem.addr = I_MEM_RDATA + ONE_W;
					s_d.state    = ST_RS_RD;
				end
			end
			ST_RS_RD: begin
				if (I_MEM_ACK) begin
					if (s_q.cnt == RESTORE_LAST) begin
						s_d.ovf       = I_MEM_RDATA[SIGN_BIT]; // [RL18]
						s_d.mem.we    = 1'b1;
						s_d.mem.addr  = s_q.ext; // [RL19]
						s_d.mem.wdata = ptr_m10; // [RL19]
						s_d.state     = ST_RS_WB;
					end else begin
						s_d.rf[s_q.cnt] = I_MEM_RDATA; // [RL18]
						s_d.cnt         = s_q.cnt + 4'h1;
						s_d.mem.addr    = s_q.mem.addr + ONE_W;
					end
				end
			end
			ST_RS_WB: begin
				if (I_MEM_ACK) begin
					s_d.mem        = '0;
					s_d.res.done   = 1'b1;
					s_d.res.next_p = s_q.p + TWO_W; // [RL20]
					s_d.state      = ST_IDLE;
				end
			end
			default: begin
				s_d.mem   = '0;
				s_d.state = ST_IDLE;
			end
		endcase
		s_d.busy = s_d.state != ST_IDLE;
	end

	always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign O_MEM  = s_q.mem;
	assign O_UM   = s_q.um;
	assign O_RES  = s_q.res;
	assign O_REGS = s_q.rf;
	assign O_OVF  = s_q.ovf;
	assign O_BUSY = s_q.busy;

	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (I_SYS_RST);

	a_skip_next: assert property (take && dec_skip |=> O_RES.done // [RL3]
		&& O_RES.next_p == $past(skip_next)) else $error("skip target wrong");
	a_skip_pos_fail: assert property (take && dec_skip && sk.cnd[1:0] == TST_POS // [RL5]
		&& sel_val[SIGN_BIT] |=> O_RES.next_p == $past(I_P) + ONE_W)
		else $error("positive test took skip on negative value");
	a_rep_back: assert property (take && rep_ok && !dec_sum[SIGN_BIT] // [RL7]
		|=> O_RES.done && O_RES.next_p == $past(rep_back)) else $error("repeat target wrong");
	a_xfer_copy: assert property (take && xfer_ok // [RL11]
		|=> s_q.rf[{1'b0, xq.rb}] == $past(xf_src)) else $error("transfer not copied");
	a_priv_block: assert property (take && misc_nz && !I_PROG_PROTECTED // [RL13]
		|=> O_RES.viol && !O_RES.done && !O_BUSY) else $error("privileged op not refused");
	a_um_zero: assert property (take && is_lmm && s_q.rf[IDX_Q] == 16'h0000 // [RL15]
		&& I_PROG_PROTECTED |=> O_RES.done && !O_BUSY && !O_UM.we)
		else $error("zero count load moved data");
	a_um_count: assert property (O_UM.we |-> O_REGS[IDX_Q] == $past(O_REGS[IDX_Q]) - ONE_W // [RL17]
		&& O_REGS[IDX_R2] == $past(O_REGS[IDX_R2]) + TWO_W) else $error("load counters off");
	a_fld_lock: assert property (s_q.state == ST_FLD_WR // [RL22]
		|-> O_MEM.lock && O_MEM.req && O_MEM.we) else $error("field write not locked");
	a_set_ones: assert property (s_q.state == ST_FLD_WR // [RL1]
		|-> (O_MEM.wdata & fmask) == fmask) else $error("field not set to ones");
	a_rs_step: assert property (s_q.state == ST_RS_WB // [RL19]
		|-> O_MEM.addr == s_q.ext && O_MEM.wdata == ptr_m10) else $error("pointer writeback wrong");
	a_rs_len: assert property (s_q.state == ST_RS_WB && I_MEM_ACK // [RL20]
		|=> O_RES.done && O_RES.next_p == $past(s_q.p) + TWO_W) else $error("restore next P wrong");
endmodule : srm_exec

// >>> dv/srm_mem_model.sv
// Main memory stand-in for the executor: answers each held request with a one-cycle ack.
// Assumes req stays up until ack; slow mode stretches every answer after the first.
`timescale 1ns/100ps
module srm_mem_model
	import srm_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire srm_mem_s    i_mem,
	input  wire logic        i_slow,
	output logic             o_ack,
	output logic [15:0]      o_rdata
);
	logic [15:0] mem [0:65535];
	logic [2:0]  wait_q;

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_ack   <= 1'b0;
			o_rdata <= 16'h0000;
			wait_q  <= 3'h0;
		end else begin
			o_ack   <= 1'b0;
			// Stale data flips so a late sample never passes for valid
			o_rdata <= ~o_rdata;
			if (i_mem.req && !o_ack) begin
				if (wait_q != 3'h0) begin
					wait_q <= wait_q - 3'h1;
				end else begin
					o_ack  <= 1'b1;
					wait_q <= i_slow ? 3'h3 : 3'h0;
					if (i_mem.we) begin
						mem[i_mem.addr] <= i_mem.wdata;
					end else begin
						o_rdata <= mem[i_mem.addr];
					end
				end
			end
		end
	end
endmodule : srm_mem_model

// >>> dv/skip_repeat_misc_instr_exec_tb_top.sv
// Self-checking bench for the skip/repeat/misc executor.
// Assumes srm_mem_model as main memory; registers seeded through the write port.
`timescale 1ns/100ps
module skip_repeat_misc_instr_exec_tb_top
	import srm_pkg::*;
;
	localparam logic [4:0]  F_DONE = 5'h10;
	localparam logic [4:0]  F_ALT  = 5'h08;
	localparam logic [4:0]  F_VIOL = 5'h04;
	localparam logic [4:0]  F_RSVD = 5'h02;
	localparam logic [4:0]  F_INTR = 5'h01;
	localparam logic [15:0] ODD_I [11] = '{16'h0000, 16'h0605, 16'h0631, 16'h0600, 16'h0700,
		16'h0709, 16'h0701, 16'h0720, 16'h0B00, 16'h0B21, 16'h0B11};
	localparam logic [4:0]  ODD_F [11] = '{F_ALT, F_RSVD, F_RSVD, F_ALT, F_ALT, F_RSVD,
		F_RSVD, F_RSVD, F_DONE, F_ALT, F_ALT};

	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        issue = 1'b0;
	logic        prot = 1'b1;
	logic        intr_pend = 1'b0;
	logic        rf_we = 1'b0;
	logic        slow = 1'b0;
	logic [3:0]  rf_idx = 4'h0;
	logic [15:0] instr = 16'h0000, ext = 16'h0000, p = 16'h0000, p_after = 16'h0000;
	logic [15:0] ea = 16'h0000, rf_wdata = 16'h0000;
	logic        ack, ovf_o, busy_o, ovx;
	logic        lock_seen = 1'b0;
	logic [15:0] rdata, v, pc, e, x, s_ea, s_pa, r1, r2;
	logic [15:0] sv [1:9];
	logic [31:0] seed = 32'h00016706, n;
	logic [3:0]  c, k, ra, rb;
	logic [1:0]  op;
	srm_mem_s    mem_o;
	srm_um_s     um_o;
	srm_um_s     umq [$];
	srm_res_s    res_o, got;
	srm_rf_t     regs_o;
	int          error_cnt = 0, comparisons = 0, cyc = 0, i, j;

	srm_exec DUT (.I_CORE_CLK(clk), .I_SYS_RST(rst), .I_ISSUE(issue), .I_INSTR(instr),
		.I_EXT_WORD(ext), .I_P(p), .I_P_AFTER(p_after), .I_EA(ea),
		.I_PROG_PROTECTED(prot), .I_INTR_PEND(intr_pend), .I_MEM_ACK(ack),
		.I_MEM_RDATA(rdata), .I_RF_WE(rf_we), .I_RF_IDX(rf_idx), .I_RF_WDATA(rf_wdata),
		.O_MEM(mem_o), .O_UM(um_o), .O_RES(res_o), .O_REGS(regs_o), .O_OVF(ovf_o),
		.O_BUSY(busy_o));
	srm_mem_model u_mem (.i_clk(clk), .i_rst(rst), .i_mem(mem_o), .i_slow(slow),
		.o_ack(ack), .o_rdata(rdata));

	initial begin
		forever #25 clk = ~clk;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// End-around carry, as the core's adder does
	function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[15:0] + {15'h0000, s[16]};
	endfunction : oc_add

	function automatic logic hit(input logic [1:0] t, input logic [15:0] d);
		case (t)
			2'h0: return d == 16'h0000;
			2'h1: return d != 16'h0000;
			2'h2: return !d[15];
			default: return d[15];
		endcase
	endfunction : hit

	task automatic close_out();
		$display("errors=%0d comparisons=%0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : close_out

	task automatic chk_val(input logic [15:0] g, input logic [15:0] w);
		comparisons++;
		if (g !== w) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, w);
		end
	endtask : chk_val

	task automatic chk_res(input logic [4:0] f, input logic [15:0] np);
		chk_val({11'h000, got[20:16]}, {11'h000, f});
		if (f[4] | f[0]) begin
			chk_val(got.next_p, np);
		end
	endtask : chk_res

	task automatic set_reg(input logic [3:0] ri, input logic [15:0] d);
		@(posedge clk);
		rf_we    <= 1'b1;
		rf_idx   <= ri;
		rf_wdata <= d;
		@(posedge clk);
		rf_we    <= 1'b0;
	endtask : set_reg

	// Result flags stand one cycle, so every cycle is looked at
	task automatic run(input logic [15:0] ins, input logic [15:0] xw);
		int w;
		@(posedge clk);
		issue   <= 1'b1;
		instr   <= ins;
		ext     <= xw;
		p       <= pc;
		ea      <= s_ea;
		p_after <= s_pa;
		@(posedge clk);
		issue   <= 1'b0;
		#1;
		w = 0;
		while (res_o[20:16] === 5'h00 && w < 400) begin
			@(posedge clk);
			#1;
			w++;
		end
		got = res_o;
		// Let the mid-cycle monitor log a word stored along with the result
		@(negedge clk);
		#1;
	endtask : run

	// Outputs looked at mid-cycle, where they are settled
	always @(negedge clk) begin
		if (um_o.we === 1'b1) umq.push_back(um_o);
		if (mem_o.req && mem_o.we && mem_o.lock) lock_seen = 1'b1;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			close_out();
		end
	end

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		for (i = 0; i < 48; i++) begin
			n  = rnd();
			pc = n[31:16];
			c  = i[3:0];
			k  = n[3:0] | {3'h0, c == 4'h0};
			v  = (i < 16) ? 16'h0000 : (i < 32) ? 16'hFFFF : n[23:8];
			ra = (c[3:2] == 2'h0) ? 4'h4 : {2'h0, c[3:2]};
			e  = hit(c[1:0], v) ? pc + {12'h000, k} + 16'h0001 : pc + 16'h0001;
			set_reg(ra, v);
			run({8'h00, c, k}, 16'h0000);
			chk_res(F_DONE, e);
		end
		ovx = 1'b0;
		for (i = 0; i < 24; i++) begin
			n   = rnd();
			pc  = n[31:16];
			ra  = 4'(1 + n[7:4] % 4'h7);
			k   = n[3:0];
			v   = (i == 0) ? 16'h0002 : (i == 1) ? 16'h0000 : (i == 2) ? 16'h8000 : n[23:8];
			x   = oc_add(v, 16'hFFFE);
			ovx = ovx | (v[15] & !x[15]);
			e   = x[15] ? pc + 16'h0001 : pc - {12'h000, k};
			set_reg(ra, v);
			run({8'h06, ra[2:0], 1'b0, k}, 16'h0000);
			chk_res(F_DONE, e);
			chk_val(regs_o[ra], x);
			chk_val({15'h0000, ovf_o}, {15'h0000, ovx});
		end
		pc = 16'h1000;
		for (i = 0; i < 11; i++) begin
			run(ODD_I[i], 16'h0000);
			chk_res(ODD_F[i], 16'h1001);
		end
		for (i = 0; i < 28; i++) begin
			n  = rnd();
			ra = 4'(1 + n[7:4] % 4'h7);
			rb = 4'(1 + n[11:8] % 4'h7);
			op = (i < 16) ? 2'h0 : 2'(1 + i % 3);
			set_reg(rb, n[15:0]);
			set_reg(ra, n[31:16]);
			e  = (op == 2'h0 || ra == rb) ? n[31:16] : n[15:0];
			run({8'h07, ra[2:0], op, rb[2:0]}, 16'h0000);
			chk_res((op == 2'h0) ? F_DONE : F_RSVD, pc + 16'h0001);
			chk_val(regs_o[rb], e);
		end
		set_reg(4'h5, 16'h0002);
		@(posedge clk);
		prot <= 1'b0;
		run(16'h0B01, 16'h0000);
		chk_res(F_VIOL, pc);
		run(16'h0B02, 16'h0080);
		chk_res(F_VIOL, pc);
		chk_val(regs_o[5], 16'h0002);
		prot <= 1'b1;
		for (i = 0; i < 12; i++) begin
			n    = rnd();
			@(posedge clk);
			slow <= i[0];
			s_ea = {8'h01, n[7:0]};
			s_pa = n[31:16] ^ 16'h5A5A;
			c    = (i == 0) ? 4'hF : n[11:8];
			k    = (i == 0) ? 4'hF : 4'(n[15:12] % ({1'b0, c} + 5'h01));
			u_mem.mem[s_ea] = n[31:16];
			e    = n[31:16] | ((16'hFFFF >> (4'hF - k)) << (c - k));
			lock_seen = 1'b0;
			run(16'h0507, {c, k, 8'h00});
			chk_res(F_DONE, s_pa);
			chk_val(u_mem.mem[s_ea], e);
			chk_val({15'h0000, lock_seen}, 16'h0001);
			chk_val({14'h0000, busy_o, mem_o.lock}, 16'h0000);
		end
		u_mem.mem[s_ea] = 16'h1234;
		run(16'h0507, 16'h2500);
		chk_res(F_RSVD, pc);
		chk_val(u_mem.mem[s_ea], 16'h1234);
		r1 = 16'h1203;
		r2 = 16'h0040;
		for (j = 0; j < 12; j++) begin
			n = rnd();
			u_mem.mem[r2 + j] = n[15:0];
		end
		set_reg(4'h5, 16'h0002);
		set_reg(4'h1, r1);
		set_reg(4'h2, r2);
		umq.delete();
		run(16'h0B01, 16'h0000);
		chk_res(F_DONE, pc + 16'h0001);
		chk_val(16'(umq.size()), 16'h0002);
		for (j = 0; j < 2; j++) begin
			chk_val({3'h0, umq[j].addr}, r1 + j[15:0]);
			chk_val(umq[j].data[31:16], u_mem.mem[r2 + 2 * j]);
			chk_val(umq[j].data[15:0], u_mem.mem[r2 + 2 * j + 1]);
		end
		chk_val(regs_o[5], 16'h0000);
		chk_val(regs_o[1], r1 + 16'h0002);
		chk_val(regs_o[2], r2 + 16'h0004);
		run(16'h0B01, 16'h0000);
		chk_res(F_DONE, pc + 16'h0001);
		chk_val(16'(umq.size()), 16'h0002);
		set_reg(4'h5, 16'h0003);
		intr_pend <= 1'b1;
		run(16'h0B01, 16'h0000);
		chk_res(F_INTR, pc);
		chk_val(16'(umq.size()), 16'h0003);
		chk_val(regs_o[5], 16'h0002);
		chk_val(regs_o[1], r1 + 16'h0003);
		chk_val(regs_o[2], r2 + 16'h0006);
		intr_pend <= 1'b0;
		for (j = 0; j < 2; j++) begin
			@(posedge clk);
			slow <= j[0];
			x = 16'h0300 + 16'(j * 32);
			u_mem.mem[16'h0080] = x;
			for (i = 1; i < 10; i++) begin
				n = rnd();
				sv[i] = (i == 9) ? {j[0], n[14:0]} : n[15:0];
				u_mem.mem[x + i] = sv[i];
			end
			run(16'h0B02, 16'h0080);
			chk_res(F_DONE, pc + 16'h0002);
			for (i = 1; i < 9; i++) begin
				chk_val(regs_o[i], sv[i]);
			end
			chk_val({15'h0000, ovf_o}, {15'h0000, j[0]});
			chk_val(u_mem.mem[16'h0080], oc_add(x, 16'hFFF5));
			for (i = 1; i < 10; i++) begin
				chk_val(u_mem.mem[x + i], sv[i]);
			end
		end
		close_out();
	end
endmodule : skip_repeat_misc_instr_exec_tb_top
